// ==== hdl/i2c_target.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.svh"
module i2c_target (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clr,
	input  wire logic       scl_s,
	input  wire logic       sda_s,
	input  wire logic [6:0] dev_addr,
	input  wire logic [7:0] rd_data,
	output logic            sda_oe,
	output logic            wr_stb,
	output logic [6:0]      wr_addr,
	output logic [7:0]      wr_data,
	output logic [6:0]      ptr
);
	led_pwm_pkg::i2c_state_e state_q;
	logic       scl_d;
	logic       sda_d;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic       rw_q;
	logic       first_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	// ==========================================================
	// Byte engine; SDA is only ever pulled low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= led_pwm_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			tx_q    <= 8'hff;
			rw_q    <= 1'b0;
			first_q <= 1'b0;
			ptr     <= 7'h00;
			sda_oe  <= 1'b0;
			wr_stb  <= 1'b0;
			wr_addr <= 7'h00;
			wr_data <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (clr || stop_c) begin // R8
				state_q <= led_pwm_pkg::ST_IDLE;
				sda_oe  <= 1'b0;
			end else if (start_c) begin
				state_q <= led_pwm_pkg::ST_ADDR;
				cnt_q   <= 4'h0;
				sda_oe  <= 1'b0;
			end else begin
				case (state_q)
					led_pwm_pkg::ST_ADDR, led_pwm_pkg::ST_RX: begin
						if (scl_rise) begin
							sh_q  <= {sh_q[6:0], sda_s};
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == 4'h8) begin
							cnt_q <= 4'h0;
							if (state_q == led_pwm_pkg::ST_ADDR) begin
								if (sh_q[7:1] == dev_addr) begin // R9
									sda_oe  <= 1'b1;
									rw_q    <= sh_q[0];
									first_q <= 1'b1;
									state_q <= led_pwm_pkg::ST_ACK_A;
								end else begin
									state_q <= led_pwm_pkg::ST_IDLE;
								end
							end else begin
								sda_oe  <= 1'b1;
								state_q <= led_pwm_pkg::ST_ACK_W;
								first_q <= 1'b0;
								if (first_q) begin
									ptr <= sh_q[6:0];
								end else begin
									wr_stb  <= 1'b1;
									wr_addr <= ptr;
									wr_data <= sh_q;
									ptr     <= ptr + 7'h1; // R12 R17
								end
							end
						end
					end
					led_pwm_pkg::ST_ACK_A: begin
						if (scl_fall) begin
							if (rw_q) begin
								sda_oe  <= ~rd_data[7]; // R14
								tx_q    <= {rd_data[6:0], 1'b1};
								cnt_q   <= 4'h1;
								state_q <= led_pwm_pkg::ST_TX;
							end else begin
								sda_oe  <= 1'b0;
								state_q <= led_pwm_pkg::ST_RX;
							end
						end
					end
					led_pwm_pkg::ST_ACK_W: begin
						if (scl_fall) begin
							sda_oe  <= 1'b0;
							state_q <= led_pwm_pkg::ST_RX;
						end
					end
					led_pwm_pkg::ST_TX: begin
						if (scl_fall) begin
							if (cnt_q == 4'h8) begin
								sda_oe  <= 1'b0;
								ptr     <= ptr + 7'h1; // R12
								state_q <= led_pwm_pkg::ST_ACK_R;
							end else begin
								sda_oe <= ~tx_q[7];
								tx_q   <= {tx_q[6:0], 1'b1};
								cnt_q  <= cnt_q + 4'h1;
							end
						end
					end
					led_pwm_pkg::ST_ACK_R: begin
						if (scl_rise) begin
							sh_q[0] <= sda_s;
						end else if (scl_fall) begin
							if (sh_q[0]) begin
								state_q <= led_pwm_pkg::ST_IDLE;
							end else begin
								sda_oe  <= ~rd_data[7];
								tx_q    <= {rd_data[6:0], 1'b1};
								cnt_q   <= 4'h1;
								state_q <= led_pwm_pkg::ST_TX;
							end
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	a_ptr_after_write: assert property (@(posedge clk_sys) disable iff (rst) // R17
		wr_stb |-> ptr == wr_addr + 7'h1) else $error("pointer did not advance on write");
	a_ack_on_match: assert property (@(posedge clk_sys) disable iff (rst) // R9
		(state_q == led_pwm_pkg::ST_ACK_A && $changed(state_q)) |-> $past(sh_q[7:1]) == dev_addr)
		else $error("acknowledged a foreign address");
	a_idle_released: assert property (@(posedge clk_sys) disable iff (rst) // R14
		(state_q == led_pwm_pkg::ST_IDLE) |-> !sda_oe) else $error("SDA pulled while idle");
endmodule : i2c_target
`default_nettype wire

// ==== hdl/rgb_led_pwm_driver_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.svh"
// Contract
// R1 - 36 channels, combined fast and slow modulation
// R2 - Slow stage 127Hz, can disable; fast 32kHz
// R3 - Slow stage base, 254Hz or 508Hz
// R4 - 8-bit fast rate 32/64/128kHz; 10-bit 32kHz
// R5 - Channels grouped green, red, blue by position
// R6 - Each color group has 8-bit current code
// R7 - Shutdown by low pin or software bit
// R8 - Pin rising edge resets I2C engine
// R9 - 7-bit address, direction bit last, zero writes
// R10 - Upper five address bits fixed, two strapped
// R11 - Strap: ground 00, supply 11, SCL 01, SDA 10
// R12 - Register pointer auto-increments across bytes
// R13 - Serial clock up to 1MHz
// R14 - SCL input only; SDA open-drain pull-down
// R15 - Optional staggered start over six phase groups
// R16 - Optional 180 degree phase on some outputs
// R17 - Pointer advances during each data acknowledge
// R18 - Group current is max times code over 256
module rgb_led_pwm_driver_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        scl_pin,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        shutdown_n_pin,
	input  wire logic        strap_pin,
	output logic [35:0]      led_channel_outputs,
	output logic [7:0]       group_current_code_g,
	output logic [7:0]       group_current_code_r,
	output logic [7:0]       group_current_code_b,
	output logic             chip_shutdown
);
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_SDB = 2;
	localparam int SY_STR = 3;
	localparam logic [15:0] INC_10   = `STEP_INC(`HF_BASE_HZ, `HF_STEPS_10);
	localparam logic [15:0] INC_8_LO = `STEP_INC(`HF_BASE_HZ, `HF_STEPS_8);
	localparam logic [15:0] INC_8_MI = `STEP_INC(`HF_MID_HZ, `HF_STEPS_8);
	localparam logic [15:0] INC_8_HI = `STEP_INC(`HF_TOP_HZ, `HF_STEPS_8);

	logic [3:0]  meta_q;
	logic [3:0]  sync_q;
	logic        sdb_d;
	logic        i2c_clr_q;
	logic        seen_hi_q;
	logic        seen_lo_q;
	logic        diff_scl_q;
	logic        diff_sda_q;
	logic [1:0]  warm_q;
	logic [1:0]  strap_bits;
	logic [6:0]  dev_addr;
	logic [7:0]  regs_q [0:`REG_COUNT-1];
	logic [7:0]  live_q [0:`REG_COUNT-1];
	logic        wr_stb;
	logic [6:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [6:0]  ptr;
	logic [7:0]  rd_data;
	logic        i2c_oe;
	logic [7:0]  ctrl;
	logic [7:0]  phase;
	logic        pms;
	logic        rgbm;
	logic [1:0]  hfps;
	logic [15:0] acc_q;
	logic [15:0] inc;
	logic [16:0] acc_sum;
	logic        tick;
	logic [9:0]  hf_cnt_q;
	logic [9:0]  hf_top;
	logic [7:0]  lf_cnt_q;
	logic        shut_q;
	logic [35:0] on_vec;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= 4'hf;
			sync_q <= 4'hf;
		end else begin
			meta_q <= {strap_pin, shutdown_n_pin, sda_in, scl_pin}; // R13
			sync_q <= meta_q;
		end
	end

	// ==========================================================
	// Shutdown and engine reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sdb_d     <= 1'b1;
			i2c_clr_q <= 1'b0;
		end else begin
			sdb_d     <= sync_q[SY_SDB];
			i2c_clr_q <= sync_q[SY_SDB] & ~sdb_d; // R8
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shut_q        <= 1'b1;
			chip_shutdown <= 1'b1;
		end else begin
			shut_q        <= ~sync_q[SY_SDB] | ~ctrl[`CTRL_SSD]; // R7
			chip_shutdown <= ~sync_q[SY_SDB] | ~ctrl[`CTRL_SSD];
		end
	end

	// ==========================================================
	// Strap decode: learned by watching the strap against the bus lines
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			seen_hi_q  <= 1'b0;
			seen_lo_q  <= 1'b0;
			diff_scl_q <= 1'b0;
			diff_sda_q <= 1'b0;
			warm_q     <= 2'h0;
		end else begin
			// Synchroniser reset ones are not pin levels; skip them
			warm_q     <= {warm_q[0], 1'b1};
			seen_hi_q  <= seen_hi_q | (warm_q[1] & sync_q[SY_STR]);
			seen_lo_q  <= seen_lo_q | (warm_q[1] & ~sync_q[SY_STR]);
			diff_scl_q <= diff_scl_q | (warm_q[1] & (sync_q[SY_STR] ^ sync_q[SY_SCL]));
			diff_sda_q <= diff_sda_q | (warm_q[1] & (sync_q[SY_STR] ^ sync_q[SY_SDA]));
		end
	end

	// Limitation: until the bus toggles a strap on SCL or SDA reads as supply
	always_comb begin
		if (!seen_lo_q) begin
			strap_bits = `STRAP_VCC; // R11
		end else if (!seen_hi_q) begin
			strap_bits = `STRAP_GND;
		end else if (!diff_scl_q) begin
			strap_bits = `STRAP_SCL;
		end else begin
			strap_bits = `STRAP_SDA;
		end
	end

	assign dev_addr = {`I2C_ADDR_HI, strap_bits}; // R10

	// ==========================================================
	// Serial port; SCL never driven, SDA only pulled low
	i2c_target u_i2c (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.clr      (i2c_clr_q),
		.scl_s    (sync_q[SY_SCL]),
		.sda_s    (sync_q[SY_SDA]),
		.dev_addr (dev_addr),
		.rd_data  (rd_data),
		.sda_oe   (i2c_oe),
		.wr_stb   (wr_stb),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.ptr      (ptr)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sda_oe  <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			sda_oe  <= i2c_oe; // R14
			sda_out <= 1'b0;
		end
	end

	// ==========================================================
	// Register file; writes above the map are dropped, except the reset register, which clears all
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				regs_q[i] <= `REG_RST_VAL;
			end
		end else if (wr_stb) begin
			if (wr_addr == `REG_RESET) begin
				for (int i = 0; i < `REG_COUNT; i++) begin
					regs_q[i] <= `REG_RST_VAL;
				end
			end else if (wr_addr < 7'(`REG_COUNT) && wr_addr != `REG_UPDATE) begin
				regs_q[wr_addr] <= wr_data; // R12
			end
		end
	end

	// Duty bytes only take effect on an update write, so a frame never tears
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				live_q[i] <= `REG_RST_VAL;
			end
		end else if (wr_stb && wr_addr == `REG_RESET) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				live_q[i] <= `REG_RST_VAL;
			end
		end else if (wr_stb && wr_addr == `REG_UPDATE) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				live_q[i] <= regs_q[i];
			end
		end
	end

	assign rd_data = (ptr < 7'(`REG_COUNT) && ptr != `REG_UPDATE) ? regs_q[ptr] : 8'h00;
	assign ctrl    = regs_q[`REG_CTRL];
	assign phase   = regs_q[`REG_PHASE];
	assign pms     = ctrl[`CTRL_PMS];
	assign rgbm    = ctrl[`CTRL_RGBM];
	assign hfps    = ctrl[`CTRL_HFPS_LO +: 2];

	// ==========================================================
	// Group current codes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			group_current_code_g <= `REG_RST_VAL;
			group_current_code_r <= `REG_RST_VAL;
			group_current_code_b <= `REG_RST_VAL;
		end else begin
			group_current_code_g <= regs_q[`REG_GCC_G]; // R6 R18
			group_current_code_r <= regs_q[`REG_GCC_R];
			group_current_code_b <= regs_q[`REG_GCC_B];
		end
	end

	// ==========================================================
	// Step rate: fractional accumulator, slow rates are enable pulses
	always_comb begin
		if (pms) begin
			inc = INC_10; // R2
		end else begin
			case (hfps)
				2'h0:    inc = INC_8_LO; // R4
				2'h1:    inc = INC_8_MI;
				default: inc = INC_8_HI;
			endcase
		end
	end

	assign acc_sum = {1'b0, acc_q} + {1'b0, inc};
	assign tick    = acc_sum[16];
	assign hf_top  = pms ? `TOP_10 : `TOP_8;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			acc_q <= 16'h0000;
		end else begin
			acc_q <= acc_sum[15:0];
		end
	end

	// Slow stage steps once per fast period, so it tracks the fast rate
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hf_cnt_q <= 10'h000;
			lf_cnt_q <= 8'h00;
		end else if (tick) begin
			if (hf_cnt_q >= hf_top) begin
				hf_cnt_q <= 10'h000;
				lf_cnt_q <= lf_cnt_q + 8'h01; // R3
			end else begin
				hf_cnt_q <= hf_cnt_q + 10'h001;
			end
		end
	end

	// ==========================================================
	// Per-channel modulation
	genvar c;
	generate
		for (c = 0; c < `NUM_CH; c++) begin : g_ch
			localparam int RGB_SRC = (c / 3) * 3;
			localparam int PGRP    = c % `NUM_PHASE;
			localparam logic [9:0] PG = 10'(PGRP);
			localparam bit INV     = (c % 2) == 1;
			logic [7:0] hi;
			logic [7:0] lo;
			logic [7:0] lf;
			logic [1:0] fms;
			logic [9:0] duty;
			logic [9:0] offs;
			logic [9:0] pos;
			logic       hf_on;
			logic       lf_on;
			// RGB mode shares the first register of each triple
			assign hi = rgbm ? live_q[`REG_HF_BASE + 2 * RGB_SRC] // R5
			                 : live_q[`REG_HF_BASE + 2 * c];
			assign lo = rgbm ? live_q[`REG_HF_BASE + 2 * RGB_SRC + 1]
			                 : live_q[`REG_HF_BASE + 2 * c + 1];
			assign lf = rgbm ? live_q[`REG_LF_BASE + RGB_SRC] : live_q[`REG_LF_BASE + c];
			assign fms  = hi[`FMS_LO +: 2];
			assign duty = pms ? {hi[1:0], lo} : {2'b00, lo}; // R1
			always_comb begin
				offs = 10'h000;
				if (phase[`PH_DELAY]) begin
					offs = 10'(PG * (pms ? `PH_STEP_10 : `PH_STEP_8)); // R15
				end
				if (phase[`PH_INVERT] && INV) begin
					offs = offs + (pms ? `HALF_10 : `HALF_8); // R16
				end
			end
			assign pos   = (hf_cnt_q - offs) & hf_top;
			assign hf_on = pos < duty;
			assign lf_on = {2'b00, lf_cnt_q} < {2'b00, lf};
			always_comb begin
				case (fms)
					`FMS_BOTH:    on_vec[c] = hf_on & lf_on; // R1
					`FMS_HF_ONLY: on_vec[c] = hf_on; // R2
					`FMS_DC:      on_vec[c] = 1'b1;
					default:      on_vec[c] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			led_channel_outputs <= 36'h0;
		end else begin
			led_channel_outputs <= shut_q ? 36'h0 : on_vec; // R7
		end
	end

	// ==========================================================
	// Checks
	sequence s_sdb_rise;
		!sync_q[SY_SDB] ##1 sync_q[SY_SDB];
	endsequence

	sequence s_hf_wrap;
		tick && hf_cnt_q >= hf_top;
	endsequence

	a_shut_dark: assert property (@(posedge clk_sys) disable iff (rst) // R7
		shut_q |=> led_channel_outputs == 36'h0) else $error("outputs lit in shutdown");
	a_pin_rise_clr: assert property (@(posedge clk_sys) disable iff (rst) // R8
		s_sdb_rise |=> i2c_clr_q ##1 !i2c_clr_q) else $error("missing engine reset pulse");
	a_addr_upper: assert property (@(posedge clk_sys) disable iff (rst) // R10
		dev_addr[6:2] == 5'h0c) else $error("fixed address bits wrong");
	a_strap_ground: assert property (@(posedge clk_sys) disable iff (rst) // R11
		(seen_lo_q && !seen_hi_q) |-> dev_addr[1:0] == 2'h0) else $error("ground strap misread");
	a_hf_wrap_lf: assert property (@(posedge clk_sys) disable iff (rst) // R3
		s_hf_wrap |=> hf_cnt_q == 10'h000 && lf_cnt_q == $past(lf_cnt_q) + 8'h01)
		else $error("slow stage missed wrap");
	a_lf_only_on_wrap: assert property (@(posedge clk_sys) disable iff (rst) // R2
		$changed(lf_cnt_q) |-> $past(tick && hf_cnt_q >= hf_top)) else $error("slow stage stray step");
	a_hf_top_10: assert property (@(posedge clk_sys) disable iff (rst) // R4
		pms |-> hf_top == 10'h3ff && inc == 16'd53687) else $error("10-bit rate wrong");
	a_dc_mode: assert property (@(posedge clk_sys) disable iff (rst) // R1
		(!shut_q && g_ch[0].fms == 2'h2) |=> led_channel_outputs[0]) else $error("DC mode dark");
	a_group_code: assert property (@(posedge clk_sys) disable iff (rst) // R6
		(wr_stb && wr_addr == 7'h6e) |=> ##1 group_current_code_g == $past(wr_data, 2))
		else $error("green code not applied");
	a_update_copy: assert property (@(posedge clk_sys) disable iff (rst) // R12
		(wr_stb && wr_addr == 7'h6d) |=> live_q[1] == $past(regs_q[1])) else $error("update lost");
endmodule : rgb_led_pwm_driver_ctrl
`default_nettype wire

// ==== inc/led_pwm_defines.svh ====
`ifndef LED_PWM_DEFINES_SVH
`define LED_PWM_DEFINES_SVH
// ==========================================================
// Clock and modulation rates
`define CLK_HZ         40000000
`define HF_BASE_HZ     32000
`define HF_MID_HZ      64000
`define HF_TOP_HZ      128000
`define LF_BASE_HZ     127
`define LF_MID_HZ      254
`define LF_TOP_HZ      508
`define HF_STEPS_10    1024
`define HF_STEPS_8     256
// Phase accumulator increment for a given period rate and step count
`define STEP_INC(hz, n) (16'((64'd1 * (hz) * (n) * 64'd65536) / `CLK_HZ))
// ==========================================================
// Internal register offsets
`define REG_CTRL       7'h00
`define REG_HF_BASE    7'h01
`define REG_LF_BASE    7'h49
`define REG_UPDATE     7'h6d
`define REG_GCC_G      7'h6e
`define REG_GCC_R      7'h6f
`define REG_GCC_B      7'h70
`define REG_PHASE      7'h71
`define REG_RESET      7'h7f
`define REG_COUNT      114
`define REG_RST_VAL    8'h00
// ==========================================================
// Field positions
`define CTRL_SSD       0
`define CTRL_PMS       1
`define CTRL_HFPS_LO   4
`define CTRL_RGBM      6
`define PH_DELAY       0
`define PH_INVERT      1
`define FMS_LO         2
`define FMS_BOTH       2'h0
`define FMS_HF_ONLY    2'h1
`define FMS_DC         2'h2
`define FMS_OFF        2'h3
// ==========================================================
// Channels, phase groups, addressing
`define NUM_CH         36
`define NUM_PHASE      6
`define PH_STEP_10     10'h0aa
`define PH_STEP_8      10'h02a
`define HALF_10        10'h200
`define HALF_8         10'h080
`define TOP_10         10'h3ff
`define TOP_8          10'h0ff
`define I2C_ADDR_HI    5'h0c
`define STRAP_GND      2'h0
`define STRAP_SCL      2'h1
`define STRAP_SDA      2'h2
`define STRAP_VCC      2'h3
`endif

// ==== inc/led_pwm_pkg.sv ====
package led_pwm_pkg;
	typedef enum {ST_IDLE, ST_ADDR, ST_ACK_A, ST_RX, ST_ACK_W, ST_TX, ST_ACK_R} i2c_state_e;
endpackage : led_pwm_pkg

// ==== tb/i2c_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input  wire logic   clk_sys,
	input  wire logic   sda_wire,
	output logic        scl,
	output logic        sda_oe_m,
	output logic [7:0]  got_val,
	output logic [15:0] got_n
);
	// ==========================================
	// Bus phases of four clocks, changes at rising edges
	initial begin
		scl = 1'b1;
		sda_oe_m = 1'b0;
		got_val = 8'h00;
		got_n = 16'h0000;
	end
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// Data moves one clock after the fall so the device sees hold time
	task bit_io(input logic b, output logic r);
		scl <= 1'b0;
		tick(1);
		sda_oe_m <= ~b;
		tick(3);
		scl <= 1'b1;
		tick(4);
		r = sda_wire;
	endtask : bit_io
	task report(input logic [7:0] v);
		got_val <= v;
		got_n <= got_n + 16'h0001;
	endtask : report
	// Works from idle and as repeated start
	task start();
		scl <= 1'b0;
		tick(1);
		sda_oe_m <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_oe_m <= 1'b1;
		tick(4);
	endtask : start
	task stop();
		scl <= 1'b0;
		tick(1);
		sda_oe_m <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_oe_m <= 1'b0;
		tick(4);
	endtask : stop
	task tx(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		report({7'h00, r});
	endtask : tx
	// Last byte is refused so the device lets go of the line
	task rx(input logic last);
		logic [7:0] v;
		logic       r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(last, r);
		report(v);
	endtask : rx
endmodule : i2c_master_model
`default_nettype wire

// ==== tb/test_rgb_led_pwm_driver_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_rgb_led_pwm_driver_ctrl;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        shutdown_n_pin = 1'b1;
	logic        strap_pin = 1'b1;
	logic        scl, sda_oe_m, sda_out, sda_oe, chip_shutdown;
	wire logic   sda_wire;
	logic [35:0] leds;
	logic [7:0]  code_g, code_r, code_b, got_val, g, r, b;
	logic [15:0] got_n, seen_n = 16'h0000;
	logic [7:0]  exp_q[$];
	logic [7:0]  wd[$];
	int          n_fail = 0;
	int          n_tests = 0;
	int          rises;
	always #12.5 clk_sys = ~clk_sys;
	// Pull-up: high unless someone pulls low
	assign sda_wire = ~((sda_oe & ~sda_out) | sda_oe_m);
	rgb_led_pwm_driver_ctrl i_dut (
		.clk_sys(clk_sys), .rst(rst), .scl_pin(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .shutdown_n_pin(shutdown_n_pin),
		.strap_pin(strap_pin), .led_channel_outputs(leds),
		.group_current_code_g(code_g), .group_current_code_r(code_r),
		.group_current_code_b(code_b), .chip_shutdown(chip_shutdown)
	);
	i2c_master_model i_master (
		.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda_oe_m(sda_oe_m),
		.got_val(got_val), .got_n(got_n)
	);
	task check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task finish_test();
		$display("Checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// ==========================================
	// Monitor
	always @(posedge clk_sys) begin
		if (sda_oe === 1'b1) check("sda drive", sda_out, 36'h0);
		if (got_n !== seen_n) begin
			seen_n = got_n;
			if (exp_q.size() == 0) check("unexpected byte", got_val, 36'h1ff);
			else check("bus byte", got_val, exp_q.pop_front());
		end
	end
	// Address 0110 0 with strap 11, then pointer and data
	task wr(input logic [7:0] p);
		repeat (2 + wd.size()) exp_q.push_back(8'h00);
		i_master.start();
		i_master.tx(8'h66);
		i_master.tx(p);
		foreach (wd[i]) i_master.tx(wd[i]);
		i_master.stop();
		i_master.tick(8);
	endtask : wr
	task count_rises(input int n);
		logic prev;
		rises = 0;
		prev = leds[2];
		repeat (n) begin
			@(posedge clk_sys);
			if (leds[2] === 1'b1 && prev === 1'b0) rises++;
			prev = leds[2];
		end
	endtask : count_rises
	initial begin
		#2000000;
		n_fail++;
		finish_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(79));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		i_master.tick(8);
		check("reset off", chip_shutdown, 36'h1);
		check("reset codes", {code_g, code_r, code_b}, 36'h0);
		exp_q.push_back(8'h01);
		i_master.start();
		i_master.tx(8'h60);
		i_master.stop();
		g = $urandom;
		r = $urandom;
		b = $urandom;
		wd = '{g, r, b};
		wr(8'h6e);
		check("codes", {code_g, code_r, code_b}, {12'h0, g, r, b});
		exp_q = '{8'h00, 8'h00, 8'h00, g, r, b};
		i_master.start();
		i_master.tx(8'h66);
		i_master.tx(8'h6e);
		i_master.start();
		i_master.tx(8'h67);
		i_master.rx(1'b0);
		i_master.rx(1'b0);
		i_master.rx(1'b1);
		i_master.stop();
		wd = '{8'h01};
		wr(8'h00);
		check("soft on", chip_shutdown, 36'h0);
		wd = '{8'h08, 8'h00, 8'h0c, 8'h00};
		wr(8'h01);
		check("before update", leds, 36'h0);
		wd = '{8'h00};
		wr(8'h6d);
		check("dc and off", leds, 36'h1);
		wd = '{8'h06, 8'h80};
		wr(8'h05);
		wr(8'h6d);
		// Fast rate per mode over 12500 clocks: 10-bit, then 8-bit 00/01/1x
		for (int k = 0; k < 4; k++) begin
			wd = '{k == 0 ? 8'h03 : k == 1 ? 8'h01 : k == 2 ? 8'h11 : 8'h21};
			wr(8'h00);
			count_rises(12500);
			check("fast rate", (rises >= (10 << (k == 0 ? 0 : k - 1)) - 1) &&
				(rises <= (10 << (k == 0 ? 0 : k - 1)) + 1), 36'h1);
		end
		// Same duty on an inverted and a plain channel
		wd = '{8'h04, 8'h80};
		wr(8'h07);
		wr(8'h6d);
		check("phase off", leds[3] ^ leds[2], 36'h0);
		wd = '{8'h02};
		wr(8'h71);
		check("phase invert", leds[3] ^ leds[2], 36'h1);
		shutdown_n_pin <= 1'b0;
		i_master.tick(8);
		check("pin off", chip_shutdown, 36'h1);
		check("pin dark", leds, 36'h0);
		exp_q = '{8'h00, 8'h01};
		i_master.start();
		i_master.tx(8'h66);
		shutdown_n_pin <= 1'b1;
		i_master.tick(8);
		i_master.tx(8'h6e);
		i_master.stop();
		check("pin on", chip_shutdown, 36'h0);
		wd = '{8'h00};
		wr(8'h7f);
		check("clear codes", {chip_shutdown, code_g, code_r, code_b}, {11'h0, 1'b1, 24'h0});
		// Second reset with the strap on ground
		rst <= 1'b1;
		strap_pin <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		i_master.tick(8);
		check("reset again", chip_shutdown, 36'h1);
		exp_q = '{8'h00, 8'h01};
		i_master.start();
		i_master.tx(8'h60);
		i_master.stop();
		i_master.start();
		i_master.tx(8'h66);
		i_master.stop();
		i_master.tick(4);
		check("queue empty", exp_q.size(), 36'h0);
		finish_test();
	end
endmodule : test_rgb_led_pwm_driver_ctrl
`default_nettype wire
